// *** logic/ies_pkg.sv ***
// constants, codes and types of the interrupt event selector
// assumes a 32-bit apb register bus and a single cpu clock domain

package ies_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [31:0] IES_SEL_HIGH_ADDR  = 32'h019C_0000;
  localparam logic [31:0] IES_SEL_LOW_ADDR   = 32'h019C_0004;
  localparam logic [31:0] IES_POLARITY_ADDR  = 32'h019C_0008;
  localparam logic [31:0] IES_REGION_LAST    = 32'h019F_FFFF;
  localparam logic [31:0] IES_SEL_FIELD_MASK = 32'h7FFF_7FFF;
  localparam logic [31:0] IES_READ_ZERO      = 32'h0000_0000;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int IES_NUM_LINES     = 16;
  localparam int IES_FIRST_MASK    = 4;
  localparam int IES_NUM_MASKABLE  = 12;
  localparam int IES_FIELDS_PER    = 6;
  localparam int IES_CODE_W        = 5;
  localparam int IES_NUM_CODES     = 32;
  localparam int IES_NUM_EXT       = 4;
  localparam int IES_LINE_RESET    = 0;
  localparam int IES_LINE_NMI      = 1;

  // ****************************************************************
  // selector codes
  // ****************************************************************
  localparam logic [4:0] IES_CODE_HOST     = 5'h00;
  localparam logic [4:0] IES_CODE_TIMER0   = 5'h01;
  localparam logic [4:0] IES_CODE_TIMER1   = 5'h02;
  localparam logic [4:0] IES_CODE_REFRESH  = 5'h03;
  localparam logic [4:0] IES_CODE_EXT4     = 5'h04;
  localparam logic [4:0] IES_CODE_EXT5     = 5'h05;
  localparam logic [4:0] IES_CODE_EXT6     = 5'h06;
  localparam logic [4:0] IES_CODE_EXT7     = 5'h07;
  localparam logic [4:0] IES_CODE_DMA      = 5'h08;
  localparam logic [4:0] IES_CODE_DBG_DMA  = 5'h09;
  localparam logic [4:0] IES_CODE_DBG_RX   = 5'h0A;
  localparam logic [4:0] IES_CODE_DBG_TX   = 5'h0B;
  localparam logic [4:0] IES_CODE_SER0_TX  = 5'h0C;
  localparam logic [4:0] IES_CODE_SER0_RX  = 5'h0D;
  localparam logic [4:0] IES_CODE_SER1_TX  = 5'h0E;
  localparam logic [4:0] IES_CODE_SER1_RX  = 5'h0F;
  localparam logic [4:0] IES_CODE_GPIO0    = 5'h10;
  localparam logic [4:0] IES_CODE_TIMER2   = 5'h13;
  localparam logic [4:0] IES_CODE_TWO_WIRE = 5'h16;
  localparam logic [4:0] IES_CODE_NETWORK  = 5'h18;
  localparam logic [4:0] IES_CODE_VIDEO0   = 5'h19;
  localparam logic [4:0] IES_CODE_VIDEO1   = 5'h1A;
  localparam logic [4:0] IES_CODE_VIDEO2   = 5'h1B;
  localparam logic [4:0] IES_CODE_AUDIO_TX = 5'h1C;
  localparam logic [4:0] IES_CODE_AUDIO_RX = 5'h1D;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] IES_SEL_LOW_RST = {1'b0, IES_CODE_DBG_DMA, IES_CODE_DMA,
    IES_CODE_EXT7, 1'b0, IES_CODE_EXT6, IES_CODE_EXT5, IES_CODE_EXT4};
  localparam logic [31:0] IES_SEL_HIGH_RST = {1'b0, IES_CODE_TIMER1, IES_CODE_TIMER0,
    IES_CODE_HOST, 1'b0, IES_CODE_DBG_TX, IES_CODE_DBG_RX, IES_CODE_REFRESH};
  localparam logic [3:0]  IES_POL_RST = 4'h0;
  localparam logic [15:0] IES_IRQ_RST = 16'h0001;

  // lsb of field j inside a selector register; bit 15 is skipped
  function automatic int ies_field_lsb(input int j);
    return (j < 3) ? (5 * j) : (5 * j + 1);
  endfunction

  // ****************************************************************
  // event sources
  // ****************************************************************
  typedef struct packed {
    logic       host_event;
    logic       timer0_event;
    logic       timer1_event;
    logic       timer2_event;
    logic       refresh_timer_event;
    logic [3:0] gpio_event_4_7;
    logic       gpio_event_0;
    logic       dma_completion_event;
    logic       debug_dma_event;
    logic       debug_data_rx_event;
    logic       debug_data_tx_event;
    logic       serial0_tx_event;
    logic       serial0_rx_event;
    logic       serial1_tx_event;
    logic       serial1_rx_event;
    logic       two_wire_event;
    logic       network_mgmt_event;
    logic       video_port0_event;
    logic       video_port1_event;
    logic       video_port2_event;
    logic       audio_tx_event;
    logic       audio_rx_event;
  } ies_events_t;

endpackage

// *** logic/ies_edge_detect.sv ***
// edge detector for one external interrupt pin with selectable sense
// assumes the pin is already synchronous to the clock

`timescale 1ns/1ns

module ies_edge_detect (
  // clock and reset
  input  logic clk,
  input  logic rst_n,
  // pin and sense
  input  logic pin,
  input  logic falling_sel,
  // one-cycle event
  output logic pulse
);

  logic prev_reg;
  logic pulse_reg;

  // follows the pin in reset too, so a pin already high at release raises no event
  always_ff @(posedge clk) begin
    prev_reg <= pin;
  end

  // compares raw levels, so a change of sense raises no event
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
    end else if (falling_sel) begin
      pulse_reg <= prev_reg & ~pin;
    end else begin
      pulse_reg <= ~prev_reg & pin;
    end
  end

  assign pulse = pulse_reg;

endmodule

// *** logic/ies_selector.sv ***
// interrupt event selector: apb registers, event routing, cpu lines
// assumes an apb master on MCLK and event inputs synchronous to MCLK

`timescale 1ns/1ns

// Functional notes
// - The core sees sixteen interrupt lines, line 0 highest and line 15 lowest priority.
// - Line 0 carries the reset event, line 1 the nmi, and lines 2 and 3 stay low.
// - Lines 0 to 3 have fixed sources that no selector field can change.
// - Lines 4 to 15 are maskable and start out on their default sources after reset.
// - Each maskable line follows the source whose code sits in its selector field.
// - The low selector holds lines 4 to 9 in six 5-bit fields, bits 15 and 31 unused.
// - The high selector holds lines 10 to 15 in the same field layout.
// - Lines 4 to 9 default to codes 4, 5, 6, 7, 8 and 9.
// - Lines 10 to 15 default to codes 3, 10, 11, 0, 1 and 2.
// - The further codes 12-16, 19, 22 and 24-29 select their own peripheral events.
// - A polarity register sets the edge sense of each of the four external pins.
// - Addresses after the polarity register up to the region end have no effect.
module ies_selector
  import ies_pkg::*;
(
  // clock and reset
  input  logic        MCLK,
  input  logic        RST_N,
  // apb slave
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [31:0] PADDR,
  input  logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR,
  // event sources
  input  ies_events_t EVT_IN,
  input  logic [3:0]  EXT_IRQ_PIN,
  input  logic        NMI_IN,
  // processor core
  output logic [15:0] CPU_IRQ
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [31:0] sel_high_reg;
  logic [31:0] sel_low_reg;
  logic [3:0]  polarity_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic [15:0] irq_reg;
  logic [15:0] irq_next;
  logic [31:0] src_vec;
  logic [3:0]  ext_pulse;
  logic [4:0]  line_code [IES_NUM_MASKABLE];
  logic        apb_setup;
  logic        apb_commit;
  logic        in_region;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign apb_setup  = PSEL & ~PENABLE;
  assign apb_commit = PSEL & PENABLE & pready_reg;
  assign in_region  = (PADDR >= IES_SEL_HIGH_ADDR) && (PADDR <= IES_REGION_LAST);

  // answers in the first access cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= apb_setup;
    end
  end

  // read data and error are captured in the setup cycle
  always_comb begin
    prdata_next  = IES_READ_ZERO;
    pslverr_next = ~in_region;
    if (!PWRITE) begin
      case (PADDR)
        IES_SEL_HIGH_ADDR: begin
          prdata_next = sel_high_reg;
        end
        IES_SEL_LOW_ADDR: begin
          prdata_next = sel_low_reg;
        end
        IES_POLARITY_ADDR: begin
          prdata_next = {28'h0000000, polarity_reg};
        end
        default: begin
          prdata_next = IES_READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      prdata_reg  <= IES_READ_ZERO;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end else if (apb_commit) begin
      prdata_reg  <= IES_READ_ZERO;
      pslverr_reg <= 1'b0;
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = pslverr_reg;

  // ****************************************************************
  // registers
  // ****************************************************************
  // unused bits 15 and 31 are never stored
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sel_low_reg <= IES_SEL_LOW_RST;
    end else if (apb_commit && PWRITE && PADDR == IES_SEL_LOW_ADDR) begin
      sel_low_reg <= PWDATA & IES_SEL_FIELD_MASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sel_high_reg <= IES_SEL_HIGH_RST;
    end else if (apb_commit && PWRITE && PADDR == IES_SEL_HIGH_ADDR) begin
      sel_high_reg <= PWDATA & IES_SEL_FIELD_MASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      polarity_reg <= IES_POL_RST;
    end else if (apb_commit && PWRITE && PADDR == IES_POLARITY_ADDR) begin
      polarity_reg <= PWDATA[3:0];
    end
  end

  // ****************************************************************
  // external pins
  // ****************************************************************
  for (genvar i = 0; i < IES_NUM_EXT; i++) begin : g_ext
    ies_edge_detect u_edge (
      .clk         (MCLK),
      .rst_n       (RST_N),
      .pin         (EXT_IRQ_PIN[i]),
      .falling_sel (polarity_reg[i]),
      .pulse       (ext_pulse[i])
    );
  end

  // ****************************************************************
  // source vector indexed by selector code
  // ****************************************************************
  // reserved codes stay at zero and so route nothing
  always_comb begin
    src_vec                    = '0;
    src_vec[IES_CODE_HOST]     = EVT_IN.host_event;
    src_vec[IES_CODE_TIMER0]   = EVT_IN.timer0_event;
    src_vec[IES_CODE_TIMER1]   = EVT_IN.timer1_event;
    src_vec[IES_CODE_REFRESH]  = EVT_IN.refresh_timer_event;
    src_vec[IES_CODE_EXT4]     = EVT_IN.gpio_event_4_7[0] | ext_pulse[0];
    src_vec[IES_CODE_EXT5]     = EVT_IN.gpio_event_4_7[1] | ext_pulse[1];
    src_vec[IES_CODE_EXT6]     = EVT_IN.gpio_event_4_7[2] | ext_pulse[2];
    src_vec[IES_CODE_EXT7]     = EVT_IN.gpio_event_4_7[3] | ext_pulse[3];
    src_vec[IES_CODE_DMA]      = EVT_IN.dma_completion_event;
    src_vec[IES_CODE_DBG_DMA]  = EVT_IN.debug_dma_event;
    src_vec[IES_CODE_DBG_RX]   = EVT_IN.debug_data_rx_event;
    src_vec[IES_CODE_DBG_TX]   = EVT_IN.debug_data_tx_event;
    src_vec[IES_CODE_SER0_TX]  = EVT_IN.serial0_tx_event;
    src_vec[IES_CODE_SER0_RX]  = EVT_IN.serial0_rx_event;
    src_vec[IES_CODE_SER1_TX]  = EVT_IN.serial1_tx_event;
    src_vec[IES_CODE_SER1_RX]  = EVT_IN.serial1_rx_event;
    src_vec[IES_CODE_GPIO0]    = EVT_IN.gpio_event_0;
    src_vec[IES_CODE_TIMER2]   = EVT_IN.timer2_event;
    src_vec[IES_CODE_TWO_WIRE] = EVT_IN.two_wire_event;
    src_vec[IES_CODE_NETWORK]  = EVT_IN.network_mgmt_event;
    src_vec[IES_CODE_VIDEO0]   = EVT_IN.video_port0_event;
    src_vec[IES_CODE_VIDEO1]   = EVT_IN.video_port1_event;
    src_vec[IES_CODE_VIDEO2]   = EVT_IN.video_port2_event;
    src_vec[IES_CODE_AUDIO_TX] = EVT_IN.audio_tx_event;
    src_vec[IES_CODE_AUDIO_RX] = EVT_IN.audio_rx_event;
  end

  // ****************************************************************
  // field extraction
  // ****************************************************************
  for (genvar j = 0; j < IES_NUM_MASKABLE; j++) begin : g_field
    if (j < IES_FIELDS_PER) begin : g_low
      assign line_code[j] = sel_low_reg[ies_field_lsb(j) +: IES_CODE_W];
    end else begin : g_high
      assign line_code[j] =
        sel_high_reg[ies_field_lsb(j - IES_FIELDS_PER) +: IES_CODE_W];
    end
  end

  // ****************************************************************
  // cpu interrupt lines
  // ****************************************************************
  // index is the priority: line 0 first, line 15 last
  always_comb begin
    irq_next                 = '0;
    irq_next[IES_LINE_RESET] = 1'b0;
    irq_next[IES_LINE_NMI]   = NMI_IN;
    for (int k = 0; k < IES_NUM_MASKABLE; k++) begin
      // a shared code drives every line that selects it
      irq_next[IES_FIRST_MASK + k] = src_vec[line_code[k]];
    end
  end

  // the reset line is high while reset is held
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      irq_reg <= IES_IRQ_RST;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign CPU_IRQ = irq_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK);
  endclocking

  default disable iff (!RST_N);

  sequence s_wr_setup(logic [31:0] a);
    PSEL && !PENABLE && PWRITE && PADDR == a;
  endsequence

  sequence s_wr_access(logic [31:0] a);
    PSEL && PENABLE && PWRITE && PADDR == a;
  endsequence

  sequence s_rd_setup(logic [31:0] a);
    PSEL && !PENABLE && !PWRITE && PADDR == a;
  endsequence

  sequence s_hole_setup;
    PSEL && !PENABLE && PADDR > IES_POLARITY_ADDR && PADDR <= IES_REGION_LAST;
  endsequence

  fixed_lines_a: assert property (
    CPU_IRQ[3:2] == 2'b00 && CPU_IRQ[1] == ($past(RST_N) ? $past(NMI_IN) : 1'b0)
  ) else $error("fixed lines 1 to 3 wrong");

  reset_line_a: assert property (
    $rose(RST_N) |-> CPU_IRQ[0] ##1 !CPU_IRQ[0]
  ) else $error("reset line does not follow reset");

  low_default_a: assert property (
    $rose(RST_N) |-> sel_low_reg == IES_SEL_LOW_RST && line_code[4] == IES_CODE_DMA
  ) else $error("low selector default wrong");

  high_default_a: assert property (
    $rose(RST_N) |-> sel_high_reg == IES_SEL_HIGH_RST && line_code[9] == IES_CODE_HOST
  ) else $error("high selector default wrong");

  low_write_a: assert property (
    s_wr_setup(IES_SEL_LOW_ADDR) ##1 s_wr_access(IES_SEL_LOW_ADDR)
    |=> sel_low_reg == ($past(PWDATA) & IES_SEL_FIELD_MASK)
  ) else $error("low selector write lost");

  high_write_a: assert property (
    s_wr_setup(IES_SEL_HIGH_ADDR) ##1 s_wr_access(IES_SEL_HIGH_ADDR)
    |=> sel_high_reg == ($past(PWDATA) & IES_SEL_FIELD_MASK) && !PREADY
  ) else $error("high selector write lost");

  read_back_a: assert property (
    s_rd_setup(IES_SEL_LOW_ADDR) |=> PREADY && PRDATA == $past(sel_low_reg)
  ) else $error("low selector read back wrong");

  reserved_hole_a: assert property (
    PSEL && PENABLE && PREADY && PWRITE && PADDR > IES_POLARITY_ADDR
    |=> $stable(sel_low_reg) && $stable(sel_high_reg) && $stable(polarity_reg)
  ) else $error("reserved write changed a register");

  rise_sense_a: assert property (
    !polarity_reg[1] && $rose(EXT_IRQ_PIN[1]) |=> ext_pulse[1] ##1 !ext_pulse[1]
  ) else $error("rising edge missed on pin 5");

  fall_sense_a: assert property (
    polarity_reg[0] && $fell(EXT_IRQ_PIN[0]) |=> ext_pulse[0]
  ) else $error("falling edge missed on pin 4");

  // register bus answers
  high_read_a: assert property (
    s_rd_setup(IES_SEL_HIGH_ADDR) |=> PREADY && PRDATA == $past(sel_high_reg)
  ) else $error("high selector read back wrong");

  pol_read_a: assert property (
    s_rd_setup(IES_POLARITY_ADDR)
    |=> PREADY && PRDATA == {28'h0000000, $past(polarity_reg)}
  ) else $error("polarity read back wrong");

  pol_write_a: assert property (
    s_wr_setup(IES_POLARITY_ADDR) ##1 s_wr_access(IES_POLARITY_ADDR)
    |=> polarity_reg == $past(PWDATA[3:0])
  ) else $error("polarity write lost");

  hole_read_a: assert property (
    s_hole_setup |=> PREADY && !PSLVERR && PRDATA == IES_READ_ZERO
  ) else $error("reserved space answered wrong");

  outside_error_a: assert property (
    PSEL && !PENABLE && !in_region |=> PREADY && PSLVERR
  ) else $error("access outside region not flagged");

  // values after reset
  pol_default_a: assert property (
    $rose(RST_N) |-> polarity_reg == IES_POL_RST
  ) else $error("polarity default wrong");

  mask_default_a: assert property (
    $rose(RST_N) |-> line_code[0] == IES_CODE_EXT4 && line_code[11] == IES_CODE_TIMER1
  ) else $error("maskable line default wrong");

  // routing and pins
  shared_code_a: assert property (
    line_code[0] == line_code[11] |=> CPU_IRQ[4] == CPU_IRQ[15]
  ) else $error("shared code not on both lines");

  pin_route_a: assert property (
    ext_pulse[3] && line_code[3] == IES_CODE_EXT7 |=> CPU_IRQ[7]
  ) else $error("pin 7 event not on its line");

  for (genvar m = 0; m < IES_NUM_MASKABLE; m++) begin : g_chk
    route_line_a: assert property (
      CPU_IRQ[IES_FIRST_MASK + m] == $past(src_vec[line_code[m]])
    ) else $error("maskable line not on its source");
  end

endmodule

// *** verification/ies_event_model.sv ***
// source model: turns one selector code into a one-cycle peripheral event
// assumes the bench changes code and fire by non-blocking assignment at a rising edge

`timescale 1ns/1ns

module ies_event_model
  import ies_pkg::*;
(
  // request from the bench
  input  logic [4:0]  code,
  input  logic        fire,
  // peripheral events
  output ies_events_t evt
);
  // ****************************************************************
  // code to source map
  // ****************************************************************
  always_comb begin
    evt = '0;
    if (fire) begin
      case (code)
        5'h00: evt.host_event = 1'b1;
        5'h01: evt.timer0_event = 1'b1;
        5'h02: evt.timer1_event = 1'b1;
        5'h03: evt.refresh_timer_event = 1'b1;
        5'h04, 5'h05, 5'h06, 5'h07: evt.gpio_event_4_7[code[1:0]] = 1'b1;
        5'h08: evt.dma_completion_event = 1'b1;
        5'h09: evt.debug_dma_event = 1'b1;
        5'h0A: evt.debug_data_rx_event = 1'b1;
        5'h0B: evt.debug_data_tx_event = 1'b1;
        5'h0C: evt.serial0_tx_event = 1'b1;
        5'h0D: evt.serial0_rx_event = 1'b1;
        5'h0E: evt.serial1_tx_event = 1'b1;
        5'h0F: evt.serial1_rx_event = 1'b1;
        5'h10: evt.gpio_event_0 = 1'b1;
        5'h13: evt.timer2_event = 1'b1;
        5'h16: evt.two_wire_event = 1'b1;
        5'h18: evt.network_mgmt_event = 1'b1;
        5'h19: evt.video_port0_event = 1'b1;
        5'h1A: evt.video_port1_event = 1'b1;
        5'h1B: evt.video_port2_event = 1'b1;
        5'h1C: evt.audio_tx_event = 1'b1;
        5'h1D: evt.audio_rx_event = 1'b1;
        default: evt = '0;
      endcase
    end
  end
endmodule

// *** verification/tb_ies_selector.sv ***
// self-checking bench of the interrupt event selector
// assumes an apb slave with one access cycle and registered cpu lines

`timescale 1ns/1ns

module tb_ies_selector import ies_pkg::*;;
  logic        MCLK        = 1'b0;
  logic        RST_N       = 1'b0;
  logic        PSEL        = 1'b0;
  logic        PENABLE     = 1'b0;
  logic        PWRITE      = 1'b0;
  logic [31:0] PADDR       = 32'h0000_0000;
  logic [31:0] PWDATA      = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [4:0]  src_code    = 5'h00;
  logic        src_fire    = 1'b0;
  ies_events_t evt;
  logic [3:0]  EXT_IRQ_PIN = 4'h0;
  logic        NMI_IN      = 1'b0;
  logic [15:0] CPU_IRQ;
  logic [4:0]  sel [16];
  int          mismatches  = 0;
  int          compares    = 0;

  always #5 MCLK = ~MCLK;

  ies_event_model i_ies_event_model (.code(src_code), .fire(src_fire), .evt(evt));

  ies_selector i_ies_selector (
    .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EVT_IN(evt), .EXT_IRQ_PIN(EXT_IRQ_PIN), .NMI_IN(NMI_IN),
    .CPU_IRQ(CPU_IRQ)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= addr;
    PWDATA  <= wdata;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20)
      check(32'h0, 32'h1);
    rdata = PRDATA;
    err   = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // selector word for lines base..base+5, bits 15 and 31 left clear
  function automatic logic [31:0] pack(input int base);
    int          lsb [6] = '{0, 5, 10, 16, 21, 26};
    logic [31:0] w;
    w = '0;
    for (int j = 0; j < 6; j++)
      w = w | (32'(sel[base + j]) << lsb[j]);
    return w;
  endfunction

  function automatic void set_defaults();
    logic [4:0] d [12] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                           5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};
    for (int k = 0; k < 12; k++)
      sel[k + 4] = d[k];
  endfunction

  function automatic logic [15:0] routed(input logic [4:0] c, input logic nmi);
    logic [15:0] v;
    v = {14'h0, nmi, 1'b0};
    for (int k = 4; k < 16; k++)
      if (sel[k] === c)
        v[k] = 1'b1;
    return v;
  endfunction

  task automatic wr_sel();
    logic [31:0] r;
    logic        e;
    apb(1'b1, IES_SEL_LOW_ADDR, pack(4) | 32'h8000_8000, r, e);
    apb(1'b1, IES_SEL_HIGH_ADDR, pack(10) | 32'h8000_8000, r, e);
    apb(1'b0, IES_SEL_LOW_ADDR, 32'h0, r, e);
    check(r, pack(4));
    apb(1'b0, IES_SEL_HIGH_ADDR, 32'h0, r, e);
    check(r, pack(10));
  endtask

  task automatic fire(input logic [4:0] c, input logic nmi);
    @(posedge MCLK);
    src_code <= c;
    src_fire <= 1'b1;
    NMI_IN   <= nmi;
    @(posedge MCLK);
    src_fire <= 1'b0;
    #1;
    check(32'(CPU_IRQ), 32'(routed(c, nmi)));
    @(posedge MCLK);
    #1;
    check(32'(CPU_IRQ), 32'({nmi, 1'b0}));
  endtask

  task automatic pin_edge(input int p, input logic lvl, input logic fires);
    logic [3:0] seen;
    @(posedge MCLK);
    EXT_IRQ_PIN[p] <= lvl;
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK);
      #1;
      seen[i] = CPU_IRQ[4 + p];
    end
    check(32'(seen), fires ? 32'h2 : 32'h0);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    @(posedge MCLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    check(32'(CPU_IRQ), 32'h0000_0001);
    @(posedge MCLK);
    RST_N <= 1'b1;
    set_defaults();
    apb(1'b0, IES_SEL_LOW_ADDR, 32'h0, r, e);
    check(r, pack(4));
    apb(1'b0, IES_SEL_HIGH_ADDR, 32'h0, r, e);
    check(r, pack(10));
    apb(1'b0, IES_POLARITY_ADDR, 32'h0, r, e);
    check(r, 32'h0000_0000);
    for (int k = 4; k < 16; k++)
      fire(sel[k], 1'b0);
  endtask

  // every usable code on line 4 and line 15 at once, nmi toggling meanwhile
  task automatic t_codes();
    for (int c = 0; c < 32; c++) begin
      if (!(c inside {17, 18, 20, 21, 23, 30, 31})) begin
        sel[4]  = 5'(c);
        sel[15] = 5'(c);
        wr_sel();
        fire(5'(c), c[0]);
      end
    end
  endtask

  task automatic t_space();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 32'h019C_000C, 32'h0, r, e);
    check(32'(e), 32'h0);
    apb(1'b1, 32'h019F_FFFC, 32'h0, r, e);
    apb(1'b0, 32'h019F_FFFC, 32'h0, r, e);
    check(r, 32'h0);
    apb(1'b1, 32'h01A0_0000, 32'h0, r, e);
    check(32'(e), 32'h1);
    apb(1'b0, IES_SEL_LOW_ADDR, 32'h0, r, e);
    check(r, pack(4));
    apb(1'b0, IES_SEL_HIGH_ADDR, 32'h0, r, e);
    check(r, pack(10));
    fire(sel[4], 1'b0);
  endtask

  // pins 4 and 6 on falling edge, pins 5 and 7 on rising edge
  task automatic t_polarity();
    logic [31:0] r;
    logic        e;
    set_defaults();
    wr_sel();
    apb(1'b1, IES_POLARITY_ADDR, 32'hFFFF_FFF5, r, e);
    apb(1'b0, IES_POLARITY_ADDR, 32'h0, r, e);
    check(r, 32'h0000_0005);
    for (int p = 0; p < 4; p++) begin
      pin_edge(p, 1'b1, p[0]);
      pin_edge(p, 1'b0, !p[0]);
    end
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    t_reset();
    t_codes();
    t_space();
    t_polarity();
    t_reset();
    give_verdict();
  end

  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule
